// *** rtl/srf_consts.vh ***
`ifndef SRF_CONSTS_VH
`define SRF_CONSTS_VH

// Register word byte addresses
`define SRF_ADR_CTRL   8'h00
`define SRF_ADR_ERREN  8'h04
`define SRF_ADR_STAT   8'h08
`define SRF_ADR_DATA   8'h0C
`define SRF_ADR_DMADAT 8'h10

// Control register fields
`define SRF_C_RIE    0
`define SRF_C_IDLE_INT_ENABLE   1
`define SRF_C_DMARX  2
`define SRF_C_STBY   3
`define SRF_C_WAKEAM 4
`define SRF_C_MODE9  5
`define SRF_C_EN     6
`define SRF_C_RXEN   7

// Error enable fields
`define SRF_E_OR 0
`define SRF_E_NF 1
`define SRF_E_FE 2
`define SRF_E_PE 3

// Status fields
`define SRF_S_PE   0
`define SRF_S_FE   1
`define SRF_S_NF   2
`define SRF_S_OR   3
`define SRF_S_IDLE 4
`define SRF_S_RF   5
`define SRF_S_BK   6
`define SRF_S_RP   7

`define SRF_CTRL_RST 8'h00
`define SRF_IDLE_BITS8 4'hA
`define SRF_IDLE_BITS9 4'hB

`endif

// *** rtl/srf_rx_flags.v ***
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - idle wake selected: setting standby after idle line may wake at once.
// - receive full flag sets when a completed character enters data register.
// - full flag gives CPU interrupt, or DMA request when DMA receive enabled.
// - idle flag sets after 10 or 11 ones; idle enable gates its interrupt, not the flag.
// - DMA receive enable suppresses full and idle CPU interrupts; error interrupt still asserts.
// - overrun keeps old character, drops new one, sets overrun flag.
// - noise in any bit sets noise flag; its enable gates error interrupt.
// - zero in stop bit sets framing flag; enable gates error interrupt.
// - parity failure sets parity flag; enable gates error interrupt.
// - with DMA service, DMA data read clears only receive full flag.
// - with DMA service, data read alone clears receive full flag.
// - without DMA service, status read then data read clears full flag.
// - error flags clear by status read arming, then data read.
// - after a read, later characters still load; overrun stays set.
// - wait mode: keeps running, interrupts wake, DMA continues.
// - stop mode: clock stopped, registers kept, in-flight character invalid.
// - break with clear disallowed: flag clears frozen, armed clear completes after.
// - break with clear allowed: clears work and stay cleared.
// - module enabled forces transmit pin output, receive pin input.
// - framing flag sets in the same cycle as receive full flag.
// - address mark wakes standby and sets full flag; standby masks rx irq and DMA request, not error irq.
`include "srf_consts.vh"

module srf_rx_flags (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Receiver character events
  input wire rx_done_i,
  input wire [8:0] rx_char_i,
  input wire rx_noise_i,
  input wire rx_stop_zero_i,
  input wire rx_parity_bad_i,
  input wire rx_break_i,
  input wire rx_active_i,
  input wire rx_one_bit_i,
  input wire rx_zero_bit_i,
  // System state
  input wire brk_state_i,
  input wire brk_clear_allow_i,
  input wire stop_mode_i,
  // Port pins
  input wire port_dir_tx_i,
  input wire port_dir_rx_i,
  input wire port_tx_i,
  input wire tx_ser_i,
  output wire tx_pin_o,
  output wire tx_pin_oe_o,
  output wire rx_pin_oe_o,
  // Requests
  output wire rx_irq_o,
  output wire err_irq_o,
  output wire dma_req_o,
  output wire rx_valid_o
);


  // ----------------------------------------------------------------
  // State and next values
  // ----------------------------------------------------------------
  // Control and enables
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg [3:0] erren_q;
  reg [3:0] erren_d;

  // Received data and flags
  reg [8:0] data_q;
  reg [8:0] data_d;
  reg rf_q;
  reg rf_d;
  reg idle_q;
  reg idle_d;
  reg or_q;
  reg or_d;
  reg nf_q;
  reg nf_d;
  reg fe_q;
  reg fe_d;
  reg pe_q;
  reg pe_d;
  reg bk_q;
  reg bk_d;
  reg armed_q;
  reg armed_d;

  // Idle tracking and stop flush
  reg [3:0] ones_q;
  reg [3:0] ones_d;
  reg idle_seen_q;
  reg idle_seen_d;
  reg flush_q;
  reg flush_d;

  // Bus answer
  reg ack_d;
  reg [31:0] rdat_d;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Word address match
  function adr_is;
    input [7:0] adr;
    input [7:0] target;
    begin
      adr_is = (adr == target);
    end
  endfunction

  // Sticky flag, set wins over clear
  function flag_next;
    input cur;
    input set;
    input clr;
    begin
      flag_next = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire rd = acc & ~wb_we_i;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr & adr_is(wb_adr_i, `SRF_ADR_CTRL);
  wire wr_erren = wr & adr_is(wb_adr_i, `SRF_ADR_ERREN);
  wire rd_stat = rd & adr_is(wb_adr_i, `SRF_ADR_STAT);
  wire rd_cpu_data = rd & adr_is(wb_adr_i, `SRF_ADR_DATA);
  wire rd_dma_data = rd & adr_is(wb_adr_i, `SRF_ADR_DMADAT);
  wire rd_data = rd_cpu_data | rd_dma_data;
  wire dma_svc = ctrl_q[`SRF_C_RIE] & ctrl_q[`SRF_C_DMARX];
  wire stby = ctrl_q[`SRF_C_STBY];
  // clears frozen in break unless break clears allowed
  wire frz = brk_state_i & ~brk_clear_allow_i;

  // ----------------------------------------------------------------
  // Clear qualifiers
  // ----------------------------------------------------------------
  // plain data read
  wire rf_clr_dma = dma_svc & rd_data;
  wire rf_clr_two = ~dma_svc & armed_q & rd_data;
  wire rf_clr = (rf_clr_dma | rf_clr_two) & ~frz;
  // armed clear of errors; DMA read leaves errors under DMA service
  wire err_clr = armed_q & rd_cpu_data & ~frz;
  wire err_clr_dma = armed_q & rd_dma_data & ~dma_svc & ~frz;
  wire e_clr = err_clr | err_clr_dma;

  // ----------------------------------------------------------------
  // Character acceptance
  // ----------------------------------------------------------------
  // character in flight at stop is dropped
  wire char_ok = rx_done_i & ~flush_q & ~stop_mode_i;
  wire mark = ctrl_q[`SRF_C_MODE9] ? rx_char_i[8] : rx_char_i[7];
  wire am_wake = stby & ctrl_q[`SRF_C_WAKEAM] & mark;
  wire accept = char_ok & (~stby | am_wake);
  // overrun when full not yet cleared
  wire ovr = accept & rf_q & ~rf_clr;
  wire load = accept & ~ovr;

  wire [3:0] idle_lim = ctrl_q[`SRF_C_MODE9] ? `SRF_IDLE_BITS9 : `SRF_IDLE_BITS8;
  wire idle_hit = rx_one_bit_i & ~rx_active_i & (ones_q + 4'h1 == idle_lim);
  // immediate wake on idle already seen
  wire idle_wake = stby & ~ctrl_q[`SRF_C_WAKEAM] & (idle_hit | idle_seen_q);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @* begin
    ctrl_d = ctrl_q;
    erren_d = erren_q;
    if (wr_ctrl) begin
      ctrl_d = wb_dat_i[7:0];
    end else if (am_wake && char_ok) begin
      ctrl_d[`SRF_C_STBY] = 1'b0;
    end else if (idle_wake) begin
      ctrl_d[`SRF_C_STBY] = 1'b0;
    end
    if (wr_erren) begin
      erren_d = wb_dat_i[3:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `SRF_CTRL_RST;
      erren_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      erren_q <= erren_d;
    end
  end

  // ----------------------------------------------------------------
  // Idle counter
  // ----------------------------------------------------------------
  always @* begin
    flush_d = stop_mode_i | (flush_q & rx_active_i);
  end

  always @* begin
    ones_d = ones_q;
    idle_seen_d = idle_seen_q;
    if (rx_zero_bit_i || rx_active_i) begin
      ones_d = 4'h0;
      idle_seen_d = 1'b0;
    end else if (idle_hit) begin
      ones_d = 4'h0;
      idle_seen_d = 1'b1;
    end else if (rx_one_bit_i) begin
      ones_d = ones_q + 4'h1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ones_q <= 4'h0;
      idle_seen_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      ones_q <= ones_d;
      idle_seen_q <= idle_seen_d;
      flush_q <= flush_d;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and data
  // ----------------------------------------------------------------
  always @* begin
    // arm on status read; armed state survives break
    armed_d = armed_q;
    if (rd_stat && !frz) begin
      armed_d = 1'b1;
    end else if (rf_clr || e_clr) begin
      armed_d = 1'b0;
    end
  end

  always @* begin
    // load; loads after read despite overrun
    data_d = data_q;
    if (load) begin
      data_d = rx_char_i;
    end
    rf_d = flag_next(rf_q, load, rf_clr);
    // waking idle character leaves idle flag alone
    idle_d = flag_next(idle_q, idle_hit & ~stby, e_clr);
    or_d = flag_next(or_q, ovr, e_clr);
    nf_d = flag_next(nf_q, accept & rx_noise_i, e_clr);
    // framing; same cycle as full flag
    fe_d = flag_next(fe_q, load & rx_stop_zero_i, e_clr);
    pe_d = flag_next(pe_q, load & rx_parity_bad_i, e_clr);
    bk_d = flag_next(bk_q, accept & rx_break_i, e_clr);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= 9'h000;
      armed_q <= 1'b0;
    end else begin
      data_q <= data_d;
      armed_q <= armed_d;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rf_q <= 1'b0;
      idle_q <= 1'b0;
      or_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pe_q <= 1'b0;
      bk_q <= 1'b0;
    end else begin
      rf_q <= rf_d;
      idle_q <= idle_d;
      or_q <= or_d;
      nf_q <= nf_d;
      fe_q <= fe_d;
      pe_q <= pe_d;
      bk_q <= bk_d;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  wire [7:0] stat_word;
  assign stat_word[`SRF_S_PE] = pe_q;
  assign stat_word[`SRF_S_FE] = fe_q;
  assign stat_word[`SRF_S_NF] = nf_q;
  assign stat_word[`SRF_S_OR] = or_q;
  assign stat_word[`SRF_S_IDLE] = idle_q;
  assign stat_word[`SRF_S_RF] = rf_q;
  assign stat_word[`SRF_S_BK] = bk_q;
  assign stat_word[`SRF_S_RP] = rx_active_i;

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always @* begin
    ack_d = acc;
    rdat_d = 32'h00000000;
    if (rd) begin
      case (wb_adr_i)
        `SRF_ADR_CTRL: rdat_d = {24'h000000, ctrl_q};
        `SRF_ADR_ERREN: rdat_d = {28'h0000000, erren_q};
        `SRF_ADR_STAT: rdat_d = {24'h000000, stat_word};
        `SRF_ADR_DATA: rdat_d = {23'h0, data_q};
        `SRF_ADR_DMADAT: rdat_d = {23'h0, data_q};
        default: rdat_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Requests and pins
  // ----------------------------------------------------------------
  // CPU or DMA routing; DMA masks; standby masks; wake
  wire full_src = rf_q & ctrl_q[`SRF_C_RIE];
  wire idle_src = idle_q & ctrl_q[`SRF_C_IDLE_INT_ENABLE];
  wire cpu_mask = ctrl_q[`SRF_C_DMARX] | stby;
  assign rx_irq_o = ~cpu_mask & (full_src | idle_src);
  assign dma_req_o = dma_svc & rf_q & ~stby;
  wire or_src = or_q & erren_q[`SRF_E_OR];
  wire nf_src = nf_q & erren_q[`SRF_E_NF];
  wire fe_src = fe_q & erren_q[`SRF_E_FE];
  wire pe_src = pe_q & erren_q[`SRF_E_PE];
  assign err_irq_o = or_src | nf_src | fe_src | pe_src;
  assign rx_valid_o = rf_q;
  assign tx_pin_oe_o = ctrl_q[`SRF_C_EN] | port_dir_tx_i;
  assign tx_pin_o = ctrl_q[`SRF_C_EN] ? tx_ser_i : port_tx_i;
  assign rx_pin_oe_o = ~ctrl_q[`SRF_C_EN] & port_dir_rx_i;

endmodule

// *** bench/srf_rx_chk.sv ***
`timescale 1ns/1ps
`include "srf_consts.vh"
// ----------------
// Flag checks
// ----------------
module srf_rx_chk (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Events and state
  input wire rx_done_i,
  input wire stop_mode_i,
  input wire brk_state_i,
  input wire brk_clear_allow_i,
  input wire port_dir_rx_i,
  // Outputs
  input wire rx_pin_oe_o,
  input wire rx_irq_o,
  input wire dma_req_o,
  input wire rx_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire dma_rd = req && !wb_we_i && wb_adr_i == `SRF_ADR_DMADAT && dma_req_o;
  property p_ack; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("data outside ack");
  property p_excl; !(rx_irq_o && dma_req_o); endproperty
  a_excl: assert property (p_excl) else $error("irq with dma");
  property p_full; rx_done_i && !stop_mode_i |=> rx_valid_o; endproperty
  a_full: assert property (p_full) else $error("full not set");
  property p_dma; dma_rd && !rx_done_i && !brk_state_i |=> !rx_valid_o; endproperty
  a_dma: assert property (p_dma) else $error("dma read kept full");
  property p_stop; stop_mode_i |=> $stable(rx_valid_o); endproperty
  a_stop: assert property (p_stop) else $error("change in stop");
  property p_brk; brk_state_i && !brk_clear_allow_i && !rx_done_i |=> $stable(rx_valid_o);
  endproperty
  a_brk: assert property (p_brk) else $error("change in break");
  property p_pin; rx_pin_oe_o |-> port_dir_rx_i; endproperty
  a_pin: assert property (p_pin) else $error("rx pin driven");
  c_dma: cover property (dma_rd);
  c_irq: cover property (rx_irq_o);
  c_stop: cover property (stop_mode_i && rx_done_i);
endmodule
bind srf_rx_flags srf_rx_chk u_chk (.*);

// *** bench/srf_far_tx.sv ***
`timescale 1ns/1ps
// ----------------
// Remote transmitter
// ----------------
module srf_far_tx (
  // Clock
  input wire clk_i,
  // Character events
  output logic rx_done_o = 1'b0,
  output logic [8:0] rx_char_o = 9'h1FF,
  output logic [2:0] rx_err_o = 3'h7,
  output logic rx_active_o = 1'b0,
  output logic rx_one_bit_o = 1'b0
);
  task send(input logic [8:0] c, input logic [2:0] e);
    @(posedge clk_i);
    rx_active_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    rx_done_o <= 1'b1;
    rx_char_o <= c;
    rx_err_o <= e;
    @(posedge clk_i);
    rx_done_o <= 1'b0;
    rx_active_o <= 1'b0;
    // Stale values not held
    rx_char_o <= ~c;
    rx_err_o <= ~e;
  endtask
  task idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      rx_one_bit_o <= 1'b1;
      @(posedge clk_i);
      rx_one_bit_o <= 1'b0;
    end
  endtask
endmodule

// *** bench/test_serial_receiver_flags_dma.sv ***
`timescale 1ns/1ps
`include "srf_consts.vh"
module test_serial_receiver_flags_dma;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic brk_state_i = 1'b0, brk_clear_allow_i = 1'b0, stop_mode_i = 1'b0, rx_break_i = 1'b0;
  logic rx_zero_bit_i = 1'b0, port_dir_tx_i = 1'b0, port_dir_rx_i = 1'b0, port_tx_i = 1'b0;
  logic tx_ser_i = 1'b1;
  wire [31:0] wb_dat_o;
  wire [8:0] rx_char_i;
  wire wb_ack_o, rx_done_i, rx_noise_i, rx_stop_zero_i, rx_parity_bad_i, rx_active_i;
  wire rx_one_bit_i, tx_pin_o, tx_pin_oe_o, rx_pin_oe_o, rx_irq_o, err_irq_o, dma_req_o;
  wire rx_valid_o;
  int bad_count = 0, checked = 0, cycles = 0;
  srf_rx_flags u_dut (.*);
  srf_far_tx u_far (.clk_i(clk_i), .rx_done_o(rx_done_i), .rx_char_o(rx_char_i),
    .rx_err_o({rx_noise_i, rx_stop_zero_i, rx_parity_bad_i}), .rx_active_o(rx_active_i),
    .rx_one_bit_o(rx_one_bit_i));
  // ----------------
  // Helpers
  // ----------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_cpu;
    port_dir_rx_i <= 1'b1;
    tx_ser_i <= 1'b0;
    bus(1'b1, `SRF_ADR_CTRL, 32'hC1);
    u_far.send(9'h05A, 3'h0);
    @(negedge clk_i);
    chk({rx_irq_o, dma_req_o}, 32'h2);
    chk({tx_pin_oe_o, rx_pin_oe_o, tx_pin_o}, 32'h4);
    rd(`SRF_ADR_DATA, 32'h5A);
    chk(rx_valid_o, 32'h1);
    rd(`SRF_ADR_STAT, 32'h20);
    rd(`SRF_ADR_DATA, 32'h5A);
    chk(rx_valid_o, 32'h0);
  endtask
  task t_err;
    bus(1'b1, `SRF_ADR_ERREN, 32'hF);
    u_far.send(9'h011, 3'h2);
    u_far.send(9'h022, 3'h0);
    @(negedge clk_i);
    chk(err_irq_o, 32'h1);
    rd(`SRF_ADR_STAT, 32'h2A);
    rd(`SRF_ADR_DATA, 32'h11);
    rd(`SRF_ADR_STAT, 32'h00);
    u_far.send(9'h033, 3'h4);
    rd(`SRF_ADR_STAT, 32'h24);
    rd(`SRF_ADR_DATA, 32'h33);
  endtask
  task t_idle;
    bus(1'b1, `SRF_ADR_CTRL, 32'hC2);
    u_far.idle(9);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h0);
    u_far.idle(1);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h1);
    rd(`SRF_ADR_STAT, 32'h10);
    rd(`SRF_ADR_DATA, 32'h33);
  endtask
  task t_dma;
    bus(1'b1, `SRF_ADR_CTRL, 32'hC7);
    u_far.send(9'h044, 3'h1);
    @(negedge clk_i);
    chk({dma_req_o, rx_irq_o, err_irq_o}, 32'h5);
    rd(`SRF_ADR_DMADAT, 32'h44);
    chk(rx_valid_o, 32'h0);
    u_far.idle(10);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h0);
    rd(`SRF_ADR_STAT, 32'h11);
    rd(`SRF_ADR_DATA, 32'h44);
  endtask
  task t_hold;
    bus(1'b1, `SRF_ADR_CTRL, 32'hC1);
    stop_mode_i <= 1'b1;
    u_far.send(9'h055, 3'h0);
    stop_mode_i <= 1'b0;
    @(negedge clk_i);
    chk(rx_valid_o, 32'h0);
    u_far.send(9'h066, 3'h0);
    rd(`SRF_ADR_STAT, 32'h20);
    brk_state_i <= 1'b1;
    rd(`SRF_ADR_DATA, 32'h66);
    brk_state_i <= 1'b0;
    chk(rx_valid_o, 32'h1);
    rd(`SRF_ADR_DATA, 32'h66);
    chk(rx_valid_o, 32'h0);
  endtask
  task t_wake;
    brk_clear_allow_i <= 1'b1;
    brk_state_i <= 1'b1;
    u_far.send(9'h077, 3'h0);
    rd(`SRF_ADR_STAT, 32'h20);
    rd(`SRF_ADR_DATA, 32'h77);
    brk_state_i <= 1'b0;
    brk_clear_allow_i <= 1'b0;
    @(negedge clk_i);
    chk(rx_valid_o, 32'h0);
    bus(1'b1, `SRF_ADR_CTRL, 32'hF9);
    u_far.send(9'h1AB, 3'h0);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h1);
    rd(`SRF_ADR_CTRL, 32'hF1);
    rd(`SRF_ADR_STAT, 32'h20);
    rd(`SRF_ADR_DATA, 32'h1AB);
    bus(1'b1, `SRF_ADR_CTRL, 32'hE2);
    rx_zero_bit_i <= 1'b1;
    @(posedge clk_i);
    rx_zero_bit_i <= 1'b0;
    u_far.idle(10);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h0);
    u_far.idle(1);
    @(negedge clk_i);
    chk(rx_irq_o, 32'h1);
    rd(`SRF_ADR_STAT, 32'h10);
    rd(`SRF_ADR_DATA, 32'h1AB);
    bus(1'b1, `SRF_ADR_CTRL, 32'hEA);
    rd(`SRF_ADR_CTRL, 32'hE2);
    bus(1'b1, `SRF_ADR_CTRL, 32'hC5);
    rx_break_i <= 1'b1;
    u_far.send(9'h000, 3'h2);
    rx_break_i <= 1'b0;
    @(negedge clk_i);
    chk({dma_req_o, err_irq_o}, 32'h3);
    bus(1'b1, `SRF_ADR_CTRL, 32'hC4);
    rd(`SRF_ADR_DATA, 32'h0);
    chk(rx_valid_o, 32'h1);
    rd(`SRF_ADR_STAT, 32'h62);
    rd(`SRF_ADR_DATA, 32'h0);
    bus(1'b1, `SRF_ADR_CTRL, 32'hC5);
    chk({rx_valid_o, err_irq_o, dma_req_o}, 32'h0);
  endtask
  // ----------------
  // Run control
  // ----------------
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_cpu;
    t_err;
    t_idle;
    t_dma;
    t_hold;
    t_wake;
    end_sim;
  end
endmodule
